// *** rtl/alzc_top.sv ***
/*
 * second-sensor zone comparators with their threshold registers and status
 * assumes: the control interface front end supplies byte writes and a read address;
 * the filtered sensor delivers one sample with a one-cycle done strobe
 */
`timescale 1ns/10ps
`default_nettype none
// Operation
// - status bits 3..0 levels 5..2, 7..4 zero
// - below bright threshold: trip, bright zone
// - bright threshold code steps 4.3 uA
// - above threshold plus hysteresis: daylight zone
// - bright hysteresis code steps 4.3 uA
// - below office threshold: trip, office zone
// - office threshold code steps 2.16 uA
// - above office sum: release to bright
module alzc_top #(
	parameter int SAMPLE_W = alzc_pkg::ALZC_SAMPLE_W
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire alzc_pkg::alzc_reg_wr_type reg_wr,
	input wire logic [7:0] rd_addr,
	output logic [7:0] rd_data,
	input wire logic conv_done,
	input wire logic [SAMPLE_W-1:0] sensor2_sample,
	input wire logic sensor2_dark_cmp_out,
	input wire logic sensor2_indoor_cmp_out,
	output logic sensor2_bright_cmp_out,
	output logic sensor2_office_cmp_out,
	output alzc_pkg::alzc_zone_type zone
);
	// ************************************************************
	// registers
	// ************************************************************
	logic [7:0] bright_thr_q, bright_thr_d;
	logic [7:0] bright_hys_q, bright_hys_d;
	logic [7:0] office_thr_q, office_thr_d;
	logic [7:0] office_hys_q, office_hys_d;
	logic [7:0] rd_data_q, rd_data_d;
	logic [7:0] status;

	// codes above 250 are accepted as written; keeping within range is software's job
	always_comb
	begin
		bright_thr_d = bright_thr_q;
		bright_hys_d = bright_hys_q;
		office_thr_d = office_thr_q;
		office_hys_d = office_hys_q;
		if (reg_wr.wr)
		begin
			case (reg_wr.addr)
				alzc_pkg::ALZC_BRIGHT_THR_ADDR: bright_thr_d = reg_wr.data;
				alzc_pkg::ALZC_BRIGHT_HYS_ADDR: bright_hys_d = reg_wr.data;
				alzc_pkg::ALZC_OFFICE_THR_ADDR: office_thr_d = reg_wr.data;
				alzc_pkg::ALZC_OFFICE_HYS_ADDR: office_hys_d = reg_wr.data;
				default: ;
			endcase
		end
		case (rd_addr)
			alzc_pkg::ALZC_STATUS_ADDR: rd_data_d = status;
			alzc_pkg::ALZC_BRIGHT_THR_ADDR: rd_data_d = bright_thr_q;
			alzc_pkg::ALZC_BRIGHT_HYS_ADDR: rd_data_d = bright_hys_q;
			alzc_pkg::ALZC_OFFICE_THR_ADDR: rd_data_d = office_thr_q;
			alzc_pkg::ALZC_OFFICE_HYS_ADDR: rd_data_d = office_hys_q;
			default: rd_data_d = alzc_pkg::ALZC_UNMAPPED_READ;
		endcase
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			bright_thr_q <= alzc_pkg::ALZC_REG_RESET;
			bright_hys_q <= alzc_pkg::ALZC_REG_RESET;
			office_thr_q <= alzc_pkg::ALZC_REG_RESET;
			office_hys_q <= alzc_pkg::ALZC_REG_RESET;
			rd_data_q <= alzc_pkg::ALZC_REG_RESET;
		end
		else
		begin
			bright_thr_q <= bright_thr_d;
			bright_hys_q <= bright_hys_d;
			office_thr_q <= office_thr_d;
			office_hys_q <= office_hys_d;
			rd_data_q <= rd_data_d;
		end
	end

	assign rd_data = rd_data_q;

	// ************************************************************
	// scaled limits
	// ************************************************************
	// one code is 8 or 4 sample lsbs; 4.32 uA stands in for 4.3 uA
	function automatic logic [SAMPLE_W-1:0] scale(input logic [8:0] code, input int shift);
		scale = SAMPLE_W'({3'h0, code} << shift);
	endfunction

	logic [SAMPLE_W-1:0] bright_lo, bright_hi, office_lo, office_hi;
	assign bright_lo = scale({1'b0, bright_thr_q}, alzc_pkg::ALZC_BRIGHT_SHIFT);
	assign bright_hi = scale({1'b0, bright_thr_q} + {1'b0, bright_hys_q}, alzc_pkg::ALZC_BRIGHT_SHIFT);
	assign office_lo = scale({1'b0, office_thr_q}, alzc_pkg::ALZC_OFFICE_SHIFT);
	assign office_hi = scale({1'b0, office_thr_q} + {1'b0, office_hys_q}, alzc_pkg::ALZC_OFFICE_SHIFT);

	// ************************************************************
	// comparators and zone
	// ************************************************************
	logic bright_q, bright_d, office_q, office_d;
	alzc_pkg::alzc_zone_type zone_q, zone_d;

	// between the limits a comparator holds, which is the hysteresis
	always_comb
	begin
		bright_d = bright_q;
		office_d = office_q;
		if (conv_done)
		begin
			if (sensor2_sample < bright_lo)
				bright_d = 1'b1;
			else if (sensor2_sample > bright_hi)
				bright_d = 1'b0;
			if (sensor2_sample < office_lo)
				office_d = 1'b1;
			else if (sensor2_sample > office_hi)
				office_d = 1'b0;
		end
		case ({office_d, bright_d})
			2'h0: zone_d = alzc_pkg::ALZC_ZONE_DAYLIGHT;
			2'h1: zone_d = alzc_pkg::ALZC_ZONE_BRIGHT;
			2'h2: zone_d = alzc_pkg::ALZC_ZONE_OFFICE;
			2'h3: zone_d = alzc_pkg::ALZC_ZONE_OFFICE;
			default: zone_d = alzc_pkg::ALZC_ZONE_DAYLIGHT;
		endcase
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			bright_q <= 1'b0;
			office_q <= 1'b0;
			zone_q <= alzc_pkg::ALZC_ZONE_DAYLIGHT;
		end
		else
		begin
			bright_q <= bright_d;
			office_q <= office_d;
			zone_q <= zone_d;
		end
	end

	assign sensor2_bright_cmp_out = bright_q;
	assign sensor2_office_cmp_out = office_q;
	assign zone = zone_q;
	assign status = {alzc_pkg::ALZC_RESERVED_VAL, sensor2_dark_cmp_out, sensor2_indoor_cmp_out,
		office_q, bright_q};

	// ************************************************************
	// assertions
	// ************************************************************
	sequence s_status_read;
		rd_addr == alzc_pkg::ALZC_STATUS_ADDR;
	endsequence

	sequence s_thr_write_then_read;
		reg_wr.wr && reg_wr.addr == alzc_pkg::ALZC_BRIGHT_THR_ADDR ##1
			!reg_wr.wr && rd_addr == alzc_pkg::ALZC_BRIGHT_THR_ADDR;
	endsequence

	property p_status_layout;
		@(posedge mclk) disable iff (!reset_n)
		s_status_read |=> rd_data_q[7:4] == 4'h0 && rd_data_q[0] == $past(bright_q)
			&& rd_data_q[1] == $past(office_q) && rd_data_q[3] == $past(sensor2_dark_cmp_out)
			&& rd_data_q[2] == $past(sensor2_indoor_cmp_out);
	endproperty
	a_status_layout: assert property (p_status_layout) else $error("status read layout wrong");

	property p_bright_trip;
		@(posedge mclk) disable iff (!reset_n)
		// a conversion in the cycle after the trip may legally release it again
		conv_done && sensor2_sample < {1'b0, bright_thr_q, 3'h0} |=> bright_q ##1 (bright_q || $past(conv_done));
	endproperty
	a_bright_trip: assert property (p_bright_trip) else $error("bright comparator did not trip");

	property p_bright_zone;
		@(posedge mclk) disable iff (!reset_n)
		bright_q && !office_q |-> zone == alzc_pkg::ALZC_ZONE_BRIGHT;
	endproperty
	a_bright_zone: assert property (p_bright_zone) else $error("bright zone not selected");

	property p_daylight;
		@(posedge mclk) disable iff (!reset_n)
		conv_done && sensor2_sample > ({1'b0, bright_thr_q, 3'h0} + {1'b0, bright_hys_q, 3'h0})
			&& sensor2_sample >= {2'h0, office_thr_q, 2'h0}
			|=> !bright_q && (office_q || zone == alzc_pkg::ALZC_ZONE_DAYLIGHT);
	endproperty
	a_daylight: assert property (p_daylight) else $error("daylight zone not entered");

	property p_office_trip;
		@(posedge mclk) disable iff (!reset_n)
		conv_done && sensor2_sample < {2'h0, office_thr_q, 2'h0} |=> office_q && zone == alzc_pkg::ALZC_ZONE_OFFICE;
	endproperty
	a_office_trip: assert property (p_office_trip) else $error("office comparator did not trip");

	property p_office_release;
		@(posedge mclk) disable iff (!reset_n)
		conv_done && office_q && sensor2_sample > ({2'h0, office_thr_q, 2'h0} + {2'h0, office_hys_q, 2'h0})
			&& sensor2_sample < {1'b0, bright_thr_q, 3'h0}
			|=> !office_q && zone == alzc_pkg::ALZC_ZONE_BRIGHT;
	endproperty
	a_office_release: assert property (p_office_release) else $error("office did not release to bright");

	property p_hold_between;
		@(posedge mclk) disable iff (!reset_n)
		!conv_done |=> $stable(bright_q) && $stable(office_q);
	endproperty
	a_hold_between: assert property (p_hold_between) else $error("comparator moved without conversion");

	property p_thr_readback;
		@(posedge mclk) disable iff (!reset_n)
		s_thr_write_then_read |=> rd_data_q == $past(reg_wr.data, 2);
	endproperty
	a_thr_readback: assert property (p_thr_readback) else $error("threshold readback mismatch");
endmodule
`default_nettype wire

// *** rtl/alzc_pkg.sv ***
/*
 * shared constants and types of the ambient-light zone comparators
 * assumes: one 25 MHz clock, register access from the control interface front end
 */
package alzc_pkg;
	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [7:0] ALZC_STATUS_ADDR = 8'h31;
	localparam logic [7:0] ALZC_BRIGHT_THR_ADDR = 8'h32;
	localparam logic [7:0] ALZC_BRIGHT_HYS_ADDR = 8'h33;
	localparam logic [7:0] ALZC_OFFICE_THR_ADDR = 8'h34;
	localparam logic [7:0] ALZC_OFFICE_HYS_ADDR = 8'h35;
	localparam logic [7:0] ALZC_REG_RESET = 8'h00;
	localparam logic [7:0] ALZC_UNMAPPED_READ = 8'h00;

	// ************************************************************
	// status field positions
	// ************************************************************
	localparam int ALZC_BRIGHT_BIT = 0;
	localparam int ALZC_OFFICE_BIT = 1;
	localparam int ALZC_INDOOR_BIT = 2;
	localparam int ALZC_DARK_BIT = 3;
	localparam logic [3:0] ALZC_RESERVED_VAL = 4'h0;

	// ************************************************************
	// code scaling, sample lsb is 0.54 uA
	// ************************************************************
	localparam int ALZC_SAMPLE_W = 12;
	localparam int ALZC_BRIGHT_SHIFT = 3;
	localparam int ALZC_OFFICE_SHIFT = 2;
	localparam logic [7:0] ALZC_CODE_LIMIT = 8'hfa;

	// ************************************************************
	// types
	// ************************************************************
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] data;
	} alzc_reg_wr_type;

	typedef enum logic [1:0] {
		ALZC_ZONE_DAYLIGHT = 2'h0,
		ALZC_ZONE_BRIGHT = 2'h1,
		ALZC_ZONE_OFFICE = 2'h3
	} alzc_zone_type;
endpackage

// *** tb/alzc_sensor_model.sv ***
/*
 * model of the filtered second sensor and its outer level-4 and level-5 comparators
 * assumes: the bench calls conv for each finished conversion, one at a time
 */
`timescale 1ns/10ps
`default_nettype none
module alzc_sensor_model (
	input wire logic mclk,
	output logic conv_done,
	output logic [11:0] sensor2_sample,
	output logic sensor2_dark_cmp_out,
	output logic sensor2_indoor_cmp_out
);
	// ************************************************************
	// conversion strobe
	// ************************************************************
	initial
	begin
		conv_done = 1'b0;
		sensor2_sample = 12'h000;
		sensor2_dark_cmp_out = 1'b0;
		sensor2_indoor_cmp_out = 1'b0;
	end
	// sample inverted outside the strobe, so a stale value never looks valid
	task automatic conv(input logic [11:0] s, input logic dk, input logic ind);
		@(posedge mclk);
		#1 conv_done = 1'b1;
		sensor2_sample = s;
		sensor2_dark_cmp_out = dk;
		sensor2_indoor_cmp_out = ind;
		@(posedge mclk);
		#1 conv_done = 1'b0;
		sensor2_sample = ~s;
	endtask
endmodule
`default_nettype wire

// *** tb/test_ambient_light_zone_comparators.sv ***
/*
 * register and zone tests of the second-sensor comparators
 * assumes: the sensor model drives the sample side, the bench acts as host
 */
`timescale 1ns/10ps
`default_nettype none
module test_ambient_light_zone_comparators;
	// ************************************************************
	// bench
	// ************************************************************
	logic mclk;
	logic reset_n;
	alzc_pkg::alzc_reg_wr_type reg_wr;
	logic [7:0] rd_addr;
	logic [7:0] rd_data;
	logic conv_done;
	logic [11:0] sensor2_sample;
	logic dark;
	logic indoor;
	logic bright;
	logic office;
	alzc_pkg::alzc_zone_type zone;
	int n_errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	localparam logic [1:0] Z_DAY = 2'h0;
	localparam logic [1:0] Z_BRI = 2'h1;
	localparam logic [1:0] Z_OFF = 2'h3;
	alzc_top #(.SAMPLE_W(12)) dut (.mclk(mclk), .reset_n(reset_n), .reg_wr(reg_wr), .rd_addr(rd_addr),
		.rd_data(rd_data), .conv_done(conv_done), .sensor2_sample(sensor2_sample),
		.sensor2_dark_cmp_out(dark), .sensor2_indoor_cmp_out(indoor),
		.sensor2_bright_cmp_out(bright), .sensor2_office_cmp_out(office), .zone(zone));
	alzc_sensor_model sens (.mclk(mclk), .conv_done(conv_done), .sensor2_sample(sensor2_sample),
		.sensor2_dark_cmp_out(dark), .sensor2_indoor_cmp_out(indoor));
	initial
	begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	task automatic results;
		$display("mismatches %0d comparisons %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// a hang counts as a mismatch
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_errors++;
			results();
		end
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		#1 reg_wr = '{1'b1, a, d};
		@(posedge mclk);
		#1 reg_wr.wr = 1'b0;
	endtask
	// read data is registered: one edge after the address
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk);
		#1 rd_addr = a;
		@(posedge mclk);
		#1 chk(rd_data, exp);
	endtask
	task automatic outs(input logic b, input logic o, input logic [1:0] z);
		chk({7'h00, bright}, {7'h00, b});
		chk({7'h00, office}, {7'h00, o});
		chk({6'h00, zone}, {6'h00, z});
	endtask
	// ************************************************************
	// tests
	// ************************************************************
	initial
	begin
		reset_n = 1'b0;
		rd_addr = 8'h00;
		reg_wr = '{1'b0, 8'h00, 8'h00};
		repeat (6) @(posedge mclk);
		#1 reset_n = 1'b1;
		rd(8'h31, 8'h00);
		rd(8'h32, 8'h00);
		// host keeps codes and their sum at or below 250
		wr(8'h32, 8'h0a);
		wr(8'h33, 8'h05);
		wr(8'h34, 8'h10);
		wr(8'h35, 8'h02);
		wr(8'h31, 8'hff);
		rd(8'h32, 8'h0a);
		rd(8'h33, 8'h05);
		rd(8'h34, 8'h10);
		rd(8'h35, 8'h02);
		rd(8'h31, 8'h00);
		rd(8'h40, 8'h00);
		// bright trips below 80, releases above 120; office below 64, above 72
		sens.conv(12'h050, 1'b0, 1'b0);
		outs(1'b0, 1'b0, Z_DAY);
		sens.conv(12'h04f, 1'b1, 1'b0);
		outs(1'b1, 1'b0, Z_BRI);
		rd(8'h31, 8'h09);
		sens.conv(12'h040, 1'b0, 1'b1);
		outs(1'b1, 1'b0, Z_BRI);
		sens.conv(12'h03f, 1'b0, 1'b1);
		outs(1'b1, 1'b1, Z_OFF);
		rd(8'h31, 8'h07);
		sens.conv(12'h048, 1'b0, 1'b0);
		outs(1'b1, 1'b1, Z_OFF);
		sens.conv(12'h049, 1'b0, 1'b0);
		outs(1'b1, 1'b0, Z_BRI);
		sens.conv(12'h078, 1'b0, 1'b0);
		outs(1'b1, 1'b0, Z_BRI);
		sens.conv(12'h079, 1'b0, 1'b0);
		outs(1'b0, 1'b0, Z_DAY);
		rd(8'h31, 8'h00);
		results();
	end
endmodule
`default_nettype wire
